// ==== logic/sbt_defs.svh ====
// Word layouts and field positions of the codec test-access wrapper.
// Assumes inclusion by bare name from design files only.
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH

`define SBT_WORD_W      16
`define SBT_SAMPLE_W    15
`define SBT_LOW_CW_W    6
`define SBT_HIGH_CW_W   2
`define SBT_SYNC_BIT    0
`define SBT_SAMPLE_LSB  1
`define SBT_LOW_CW_LSB  8
`define SBT_HIGH_CW_LSB 14
`define SBT_FIFO_DEPTH  8
`define SBT_MODE_RST    2'h1

`endif

// ==== logic/sbt_pkg.sv ====
// Types shared by the codec test-access wrapper.
// Assumes sbt_defs.svh is on the include path.
`include "sbt_defs.svh"

package sbt_pkg;

    typedef enum logic [1:0] {
        SBT_CFG_ENC = 2'h1,
        SBT_CFG_DEC = 2'h2
    } sbt_cfg_type;

    // Sample fed into both encoders
    typedef struct packed {
        logic [`SBT_SAMPLE_W-1:0] low_band_sample_in;
        logic [`SBT_SAMPLE_W-1:0] high_band_sample_in;
        logic                     codec_state_reset;
    } sbt_enc_in_type;

    typedef struct packed {
        logic [`SBT_LOW_CW_W-1:0]  received_low_codeword;
        logic [`SBT_HIGH_CW_W-1:0] high_band_codeword;
        logic                      codec_state_reset;
    } sbt_dec_in_type;

    // Codec core answer for one sample
    typedef struct packed {
        logic [`SBT_LOW_CW_W-1:0]  low_band_codeword;
        logic [`SBT_HIGH_CW_W-1:0] high_band_codeword;
        logic [`SBT_SAMPLE_W-1:0]  low_band_decoded;
        logic [`SBT_SAMPLE_W-1:0]  high_band_decoded;
    } sbt_core_out_type;

    // Output words of one sample
    typedef struct packed {
        logic [`SBT_WORD_W-1:0] codeword_test_word;
        logic [`SBT_WORD_W-1:0] low_decoded_test_word;
        logic [`SBT_WORD_W-1:0] high_decoded_test_word;
    } sbt_out_words_type;

endpackage

// ==== logic/sbt_fifo.sv ====
// Synchronous FIFO for packed output words.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

`include "sbt_defs.svh"

module sbt_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = `SBT_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap bit only works for power-of-two depths
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("sbt_fifo depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } sbt_fifo_st_type;

    logic [WIDTH-1:0] mem_q [DEPTH];
    sbt_fifo_st_type  st_q;
    sbt_fifo_st_type  st_d;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign full        = (st_q.wr_ptr[AW] != st_q.rd_ptr[AW])
                         && (st_q.wr_ptr[AW-1:0] == st_q.rd_ptr[AW-1:0]);
    assign empty       = st_q.wr_ptr == st_q.rd_ptr;
    assign push        = i_in_valid && !full;
    assign pop         = i_out_ready && !empty;
    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = mem_q[st_q.rd_ptr[AW-1:0]];

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.wr_ptr = st_q.wr_ptr + {{AW{1'b0}}, 1'b1};
        end
        if (pop) begin
            st_d.rd_ptr = st_q.rd_ptr + {{AW{1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
        if (push) begin
            mem_q[st_q.wr_ptr[AW-1:0]] <= i_in_data;
        end
    end

endmodule

`default_nettype wire

// ==== logic/sbt_test_access.sv ====
// Test-access wrapper: unpacks test words for the ADPCM core, packs its answers.
// Assumes the codec core sits outside, answers one sample per strobe, and
// that the wrapper is clocked well above the sample rate.
`timescale 1ns/1ns
`default_nettype none

`include "sbt_defs.svh"

module sbt_test_access
    import sbt_pkg::*;
#(
    parameter int FIFO_DEPTH = `SBT_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_sys_rst,
    // Configuration
    input  wire logic                      i_test_mode,
    input  wire sbt_cfg_type               i_config,
    input  wire logic [1:0]                i_low_mode,
    // Test sequence generator side
    input  wire logic                      i_word_valid,
    input  wire logic [`SBT_WORD_W-1:0]    i_test_word,
    output logic                           o_word_ready,
    // Codec core, request
    output logic                           o_core_strobe,
    output logic                           o_core_test_mode,
    output logic                           o_core_dec_sel,
    output logic [1:0]                     o_core_low_mode,
    output sbt_enc_in_type                 o_core_enc,
    output sbt_dec_in_type                 o_core_dec,
    // Codec core, answer
    input  wire logic                      i_core_done,
    input  wire sbt_core_out_type          i_core_out,
    // Test sequence receiver side
    output logic                           o_out_valid,
    output sbt_out_words_type              o_out_words,
    input  wire logic                      i_out_ready,
    // Status
    output logic                           o_busy
);
    localparam int OW = $bits(sbt_out_words_type);

    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("sbt_test_access needs a FIFO of at least two words");
    end

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_PUSH = 3'h4
    } sbt_state_type;

    typedef struct packed {
        sbt_state_type     state;
        logic              word_ready;
        logic              strobe;
        logic              test_mode;
        logic              dec_sel;
        logic [1:0]        low_mode;
        sbt_enc_in_type    enc;
        sbt_dec_in_type    dec;
        sbt_out_words_type words;
        logic              push;
        logic              busy;
    } sbt_st_type;

    sbt_st_type st_q;
    sbt_st_type st_d;
    logic       fifo_ready;
    logic       fifo_valid;
    logic [OW-1:0] fifo_data;

    // Sample shifted up one place with the reset flag in bit 0; the sample is zeroed on reset
    function automatic logic [`SBT_WORD_W-1:0] pack_decoded(
        input logic [`SBT_SAMPLE_W-1:0] sample,
        input logic                     rst
    );
        logic [`SBT_SAMPLE_W-1:0] s;
        s = rst ? '0 : sample;
        return {s, rst};
    endfunction

    always_comb begin
        st_d        = st_q;
        st_d.strobe = 1'b0;
        st_d.push   = 1'b0;
        unique case (st_q.state)
            ST_IDLE: begin
                // Hold off the generator while the FIFO cannot take an answer
                st_d.word_ready = fifo_ready && !st_q.push;
                if (i_word_valid && st_q.word_ready) begin
                    st_d.word_ready = 1'b0;
                    st_d.test_mode  = i_test_mode;
                    st_d.dec_sel    = i_config == SBT_CFG_DEC;
                    st_d.low_mode   = i_low_mode;
                    st_d.enc.codec_state_reset =
                        i_test_word[`SBT_SYNC_BIT];
                    st_d.enc.low_band_sample_in =
                        i_test_word[`SBT_WORD_W-1:`SBT_SAMPLE_LSB];
                    st_d.enc.high_band_sample_in =
                        i_test_word[`SBT_WORD_W-1:`SBT_SAMPLE_LSB];
                    st_d.dec.codec_state_reset =
                        i_test_word[`SBT_SYNC_BIT];
                    st_d.dec.received_low_codeword = i_test_word[
                        `SBT_LOW_CW_LSB+`SBT_LOW_CW_W-1:`SBT_LOW_CW_LSB];
                    st_d.dec.high_band_codeword = i_test_word[
                        `SBT_HIGH_CW_LSB+`SBT_HIGH_CW_W-1:`SBT_HIGH_CW_LSB];
                    st_d.strobe = 1'b1;
                    st_d.state  = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (i_core_done) begin
                    if (st_q.dec_sel) begin
                        // Each band from its own decoder, no encoder loop
                        st_d.words.codeword_test_word = '0;
                        st_d.words.low_decoded_test_word = pack_decoded(
                            i_core_out.low_band_decoded,
                            st_q.dec.codec_state_reset);
                        st_d.words.high_decoded_test_word = pack_decoded(
                            i_core_out.high_band_decoded,
                            st_q.dec.codec_state_reset);
                    end else begin
                        st_d.words.low_decoded_test_word  = '0;
                        st_d.words.high_decoded_test_word = '0;
                        if (st_q.enc.codec_state_reset) begin
                            st_d.words.codeword_test_word =
                                {{(`SBT_WORD_W-1){1'b0}}, 1'b1};
                        end else begin
                            st_d.words.codeword_test_word = {
                                i_core_out.high_band_codeword,
                                i_core_out.low_band_codeword,
                                7'h00, 1'b0};
                        end
                    end
                    st_d.push  = 1'b1;
                    st_d.state = ST_PUSH;
                end
            end
            ST_PUSH: begin
                st_d.state = ST_IDLE;
            end
        endcase
        // Registered copy so the status pin comes straight from a flop
        st_d.busy = st_d.state != ST_IDLE;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_q       <= '0;
            st_q.state <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // FIFO always has room on push: word_ready is only raised while not full
    sbt_fifo #(
        .WIDTH (OW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (st_q.push),
        .i_in_data   (st_q.words),
        .o_in_ready  (fifo_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (i_out_ready)
    );

    assign o_word_ready     = st_q.word_ready;
    assign o_core_strobe    = st_q.strobe;
    assign o_core_test_mode = st_q.test_mode;
    assign o_core_dec_sel   = st_q.dec_sel;
    assign o_core_low_mode  = st_q.low_mode;
    assign o_core_enc       = st_q.enc;
    assign o_core_dec       = st_q.dec;
    assign o_out_valid      = fifo_valid;
    assign o_out_words      = sbt_out_words_type'(fifo_data);
    assign o_busy           = st_q.busy;

endmodule

`default_nettype wire

// ==== test/sbt_core_model.sv ====
// Behavioural codec core: answers each strobe after a settable delay.
// Assumes the wrapper strobes once and waits for done before the next.
`timescale 1ns/1ns
`default_nettype none

module sbt_core_model
    import sbt_pkg::*;
(
    // Clock
    input  wire logic             i_clk,
    // Request from the wrapper
    input  wire logic             i_strobe,
    input  wire sbt_enc_in_type   i_enc,
    input  wire sbt_dec_in_type   i_dec,
    input  wire logic [1:0]       i_mode,
    // Answer delay in cycles, set by the bench
    input  wire logic [3:0]       i_delay,
    // Answer
    output logic                  o_done,
    output sbt_core_out_type      o_out
);
    sbt_core_out_type res = '0;
    int               cnt = -1;

    initial o_done = 1'b0;
    initial o_out = '0;

    // Outside done the answer toggles, so a late sample never sees a stale match
    always @(posedge i_clk) begin
        o_done <= (cnt == 0);
        o_out  <= (cnt == 0) ? res : ~o_out;
        if (i_strobe) begin
            res <= {i_enc.low_band_sample_in[5:0], i_enc.high_band_sample_in[7:6],
                    i_dec.received_low_codeword, 7'h00, i_mode,
                    i_dec.high_band_codeword, 13'h0000};
            cnt <= int'(i_delay);
        end else if (cnt >= 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

`default_nettype wire

// ==== test/sbt_assertions.sv ====
// Port-level checker of the test-access wrapper.
// Assumes binding to sbt_test_access, one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none

module sbt_assertions
    import sbt_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_test_mode,
    input  wire sbt_cfg_type      i_config,
    input  wire logic [1:0]       i_low_mode,
    input  wire logic             i_word_valid,
    input  wire logic [15:0]      i_test_word,
    input  wire logic             o_word_ready,
    input  wire logic             o_core_strobe,
    input  wire logic             o_core_test_mode,
    input  wire logic [1:0]       o_core_low_mode,
    input  wire sbt_enc_in_type   o_core_enc,
    input  wire sbt_dec_in_type   o_core_dec,
    input  wire logic             i_core_done,
    input  wire logic             o_out_valid,
    input  wire logic             o_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_take;
        i_word_valid && o_word_ready;
    endsequence
    sequence s_take_enc;
        s_take ##0 i_config == SBT_CFG_ENC;
    endsequence

    chk_strobe_after_take: assert property (s_take |=> o_core_strobe && o_busy)
        else $error("strobe missing after take");
    chk_strobe_one_pulse: assert property (o_core_strobe |=> !o_core_strobe)
        else $error("strobe longer than one cycle");
    chk_busy_refuses: assert property (o_busy |-> !o_word_ready)
        else $error("ready while busy");
    chk_sync_to_reset: assert property (s_take |=>
        o_core_enc.codec_state_reset == $past(i_test_word[0]))
        else $error("sync bit not passed as reset");
    chk_same_sample: assert property (s_take_enc |=>
        o_core_enc.low_band_sample_in == o_core_enc.high_band_sample_in
        && o_core_enc.low_band_sample_in == $past(i_test_word[15:1]))
        else $error("encoder samples wrong");
    chk_dec_fields: assert property (s_take ##0 i_config == SBT_CFG_DEC |=>
        {o_core_dec.received_low_codeword, o_core_dec.high_band_codeword}
        == {$past(i_test_word[13:8]), $past(i_test_word[15:14])})
        else $error("decoder codewords wrong");
    chk_mode_test_pass: assert property (s_take |=>
        o_core_low_mode == $past(i_low_mode) && o_core_test_mode == $past(i_test_mode))
        else $error("mode or test mode not passed");
    chk_done_to_valid: assert property (i_core_done && !o_out_valid |-> ##[1:2] o_out_valid)
        else $error("answer not queued in time");
    chk_test_mode_held: assert property (!(i_word_valid && o_word_ready) |=>
        $stable(o_core_test_mode) && $stable(o_core_low_mode))
        else $error("test mode moved without a take");
endmodule

bind sbt_test_access sbt_assertions u_chk (
    .i_clk, .i_sys_rst, .i_test_mode, .i_config, .i_low_mode, .i_word_valid,
    .i_test_word, .o_word_ready, .o_core_strobe, .o_core_test_mode, .o_core_low_mode,
    .o_core_enc, .o_core_dec, .i_core_done, .o_out_valid, .o_busy
);

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench of the test-access wrapper with a core model.
// Assumes the core model answers within its set delay.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module tb;
    import sbt_pkg::*;
    logic clk = 0, rst = 1, tmode = 1, wvalid = 0, oready = 0;
    logic wready, strobe, ctm, dsel, done, ovalid, busy;
    logic [1:0] cmode, lmode = 2'h1;
    logic [3:0] dly = 4'h0;
    logic [15:0] word = 16'h0000;
    sbt_cfg_type cfg = SBT_CFG_ENC;
    sbt_enc_in_type cenc;
    sbt_dec_in_type cdec;
    sbt_core_out_type cout;
    sbt_out_words_type owords;
    int n_fail = 0, n_tests = 0;

    always #5 clk = ~clk;

    sbt_test_access DUT (.i_clk(clk), .i_sys_rst(rst), .i_test_mode(tmode),
        .i_config(cfg), .i_low_mode(lmode), .i_word_valid(wvalid), .i_test_word(word),
        .o_word_ready(wready), .o_core_strobe(strobe), .o_core_test_mode(ctm),
        .o_core_dec_sel(dsel), .o_core_low_mode(cmode), .o_core_enc(cenc),
        .o_core_dec(cdec), .i_core_done(done), .i_core_out(cout), .o_out_valid(ovalid),
        .o_out_words(owords), .i_out_ready(oready), .o_busy(busy));
    sbt_core_model core (.i_clk(clk), .i_strobe(strobe), .i_enc(cenc), .i_dec(cdec),
        .i_mode(cmode), .i_delay(dly), .o_done(done), .o_out(cout));

    function automatic sbt_out_words_type exp_of(sbt_cfg_type c, logic [1:0] m,
                                                 logic [15:0] w);
        exp_of = '0;
        if (c == SBT_CFG_ENC)
            exp_of.codeword_test_word = w[0] ? 16'h0001 : {w[8:1], 8'h00};
        else begin
            exp_of.low_decoded_test_word = w[0] ? 16'h0001 : {w[13:8], 7'h00, m, 1'b0};
            exp_of.high_decoded_test_word = w[0] ? 16'h0001 : {w[15:14], 14'h0000};
        end
    endfunction

    task automatic push(input sbt_cfg_type c, input logic [1:0] m, input logic [15:0] w);
        int k;
        k = 0;
        @(posedge clk);
        wvalid <= 1'b1;
        word <= w;
        cfg <= c;
        lmode <= m;
        @(negedge clk);
        while (wready !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        wvalid <= 1'b0;
        @(negedge clk);
        `CHK("strobe", 1'b1, strobe)
        `CHK("busy", 1'b1, busy)
        `CHK("test mode", tmode, ctm)
        `CHK("dec select", c == SBT_CFG_DEC, dsel)
        if (c == SBT_CFG_ENC) `CHK("enc in", {w[15:1], w[15:1], w[0]}, cenc)
        else `CHK("dec in", {w[13:8], w[15:14], w[0]}, cdec)
    endtask

    task automatic pop(input sbt_out_words_type e);
        int k;
        k = 0;
        @(negedge clk);
        while (ovalid !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        `CHK("out words", e, owords)
        `CHK("idle", 1'b0, busy)
        @(posedge clk);
        oready <= 1'b1;
        @(posedge clk);
        oready <= 1'b0;
    endtask

    task automatic test_encoder();
        logic [15:0] ws [4] = '{16'h0001, 16'h1234, 16'h7ffe, 16'h8000};
        foreach (ws[i]) begin
            push(SBT_CFG_ENC, 2'h1, ws[i]);
            pop(exp_of(SBT_CFG_ENC, 2'h1, ws[i]));
        end
        $display("test_encoder done");
    endtask

    task automatic test_decoder();
        for (int m = 1; m <= 3; m++) begin
            push(SBT_CFG_DEC, m[1:0], 16'h7f01);
            pop(exp_of(SBT_CFG_DEC, m[1:0], 16'h7f01));
            push(SBT_CFG_DEC, m[1:0], 16'haa00);
            pop(exp_of(SBT_CFG_DEC, m[1:0], 16'haa00));
        end
        $display("test_decoder done");
    endtask

    // Receiver stalls while a slow core fills the queue
    task automatic test_fifo();
        dly <= 4'h7;
        tmode <= 1'b0;
        for (int i = 0; i < 8; i++) push(SBT_CFG_ENC, 2'h1, 16'h0100 * i[7:0]);
        repeat (20) @(negedge clk);
        `CHK("full refuses", 1'b0, wready)
        for (int i = 0; i < 8; i++) pop(exp_of(SBT_CFG_ENC, 2'h1, 16'h0100 * i[7:0]));
        @(negedge clk);
        `CHK("drained", 1'b0, ovalid)
        $display("test_fifo done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        test_encoder();
        test_decoder();
        test_fifo();
        print_verdict();
    end
endmodule

`default_nettype wire
